// ---- bench/trc_checker.sv ----
/*
  Concurrent checks on the link between controller and sequencer.
  Assumes one clock, an active-low reset and instantiation beside the link.
*/
`timescale 1ns/10ps
`include "trc_defines.svh"
module trc_checker #(
  parameter int NUM_CH = 4,
  parameter int OP_TIMEOUT = 20
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [2:0] mode_sel,
  input wire logic wr_all_req,
  input wire logic busy,
  input wire logic error,
  input wire logic oc_active,
  input wire logic tx_dig_rst,
  input wire logic rx_dig_rst,
  input wire logic rx_ana_rst,
  input wire logic powerdown,
  input wire logic freq_locked
);
  logic [4:0] oc_cnt;
  logic [7:0] lock_cnt;
  logic [3:0] ch_cnt;
  logic [11:0] run_cnt;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // The offset-cancel and lock counters saturate so a long run cannot wrap them into a false pass.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      oc_cnt <= 5'h00;
      lock_cnt <= 8'h00;
      ch_cnt <= 4'h0;
      run_cnt <= 12'h000;
    end else begin
      if (oc_active && oc_cnt != 5'h1F) begin
        oc_cnt <= oc_cnt + 5'h01;
      end
      if (!freq_locked) begin
        lock_cnt <= 8'h00;
      end else if (lock_cnt != 8'hFF) begin
        lock_cnt <= lock_cnt + 8'h01;
      end
      if (wr_all_req && mode_sel == `TRC_MODE_PLL) begin
        ch_cnt <= 4'h0;
      end else if (wr_all_req && mode_sel == `TRC_MODE_CHAN) begin
        ch_cnt <= ch_cnt + 4'h1;
      end
      run_cnt <= (busy && !oc_active) ? run_cnt + 12'h001 : 12'h000;
    end
  end
  err_two_cyc_a: assert property ($rose(error) |=> error ##1 !error)
    else $error("error pulse length wrong");
  err_busy_a: assert property (error |-> !busy)
    else $error("busy high with error");
  oc_len_a: assert property ($fell(oc_active) |-> oc_cnt == 5'h10)
    else $error("offset cancel length wrong");
  pdown_oc_a: assert property (oc_active |-> !powerdown)
    else $error("powerdown during offset cancel");
  pll_rst_a: assert property (busy && mode_sel == `TRC_MODE_PLL |->
    tx_dig_rst && rx_dig_rst && rx_ana_rst)
    else $error("reset released during pll update");
  rel_order_a: assert property ($fell(tx_dig_rst) |->
    ch_cnt == NUM_CH && !rx_ana_rst && rx_dig_rst)
    else $error("reset release out of order");
  rx_lock_a: assert property ($fell(rx_dig_rst) |-> lock_cnt >= 8'h50)
    else $error("rx digital reset released early");
  run_len_a: assert property (run_cnt <= OP_TIMEOUT + 1)
    else $error("operation not abandoned");
  wr_legal_a: assert property (wr_all_req && !busy && !error && !oc_active
    |=> busy && !error ##1 !error [*2])
    else $error("legal write refused");
endmodule

// ---- bench/trc_tb.sv ----
/*
  Self-checking bench: both ends joined on one link, plus two more
  controllers driven directly with illegal, legal and stalled requests.
  Assumes the design files under rtl/ are compiled first.
*/
`timescale 1ns/10ps
`include "trc_defines.svh"
module trc_tb;
  localparam int TO = 20;
  localparam int NCH = 4;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, d;
  logic irq, st_a, st_b, stall = 1'b0, ack_en_b = 1'b1;
  logic ack_a = 1'b0;
  logic ack_b = 1'b0;
  logic ack_c = 1'b0;
  logic st_c;
  trc_pkg::trc_pma_t pma_c;
  logic [2:0] md_a;
  logic [1:0] ch_a;
  logic [2:0] mlog [8];
  logic [1:0] clog [8];
  logic [4:0] tbl [3] = '{5'b00010, 5'b00001, 5'b00110};
  int bad_count = 0;
  int compares = 0;
  int seed = 64915;
  int nops = 0;
  int n, nb;
  trc_if #(.CH_W(2)) lnk_a ();
  trc_if #(.CH_W(2)) lnk_b ();
  trc_if lnk_c ();
  // The third controller keeps every analog option and sees the same
  // requests as the second, so a legal analog write can be watched.
  assign lnk_c.mode_sel = lnk_b.mode_sel;
  assign lnk_c.chan_sel = lnk_b.chan_sel;
  assign lnk_c.rd_req = lnk_b.rd_req;
  assign lnk_c.wr_all_req = lnk_b.wr_all_req;
  assign lnk_c.wdata = lnk_b.wdata;
  assign lnk_c.freq_locked = lnk_a.freq_locked;
  assign lnk_b.freq_locked = lnk_a.freq_locked;
  always #25 core_clk = ~core_clk;
  trc_ctrl #(.OP_TIMEOUT(TO)) trc_ctrl_inst (.core_clk(core_clk),
    .resetn(resetn), .lnk(lnk_a.ctrl), .xcvr_op_start(st_a),
    .xcvr_op_write(), .xcvr_mode(md_a), .xcvr_chan(ch_a), .xcvr_pma(),
    .xcvr_op_ack(ack_a));
  trc_ctrl #(.OP_TIMEOUT(TO), .HAS_PMA_RD(1'b0), .HAS_PMA_WR(1'b0))
    trc_ctrl_inst_b (.core_clk(core_clk), .resetn(resetn),
    .lnk(lnk_b.ctrl), .xcvr_op_start(st_b), .xcvr_op_write(),
    .xcvr_mode(), .xcvr_chan(), .xcvr_pma(), .xcvr_op_ack(ack_b));
  trc_ctrl #(.OP_TIMEOUT(TO)) trc_ctrl_inst_c (.core_clk(core_clk),
    .resetn(resetn), .lnk(lnk_c.ctrl), .xcvr_op_start(st_c),
    .xcvr_op_write(), .xcvr_mode(), .xcvr_chan(), .xcvr_pma(pma_c),
    .xcvr_op_ack(ack_c));
  trc_user #(.NUM_CH(NCH)) trc_user_inst (.core_clk(core_clk),
    .resetn(resetn), .lnk(lnk_a.user), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq));
  trc_checker #(.NUM_CH(NCH), .OP_TIMEOUT(TO)) trc_checker_inst (
    .core_clk(core_clk), .resetn(resetn), .mode_sel(lnk_a.mode_sel),
    .wr_all_req(lnk_a.wr_all_req), .busy(lnk_a.busy),
    .error(lnk_a.error), .oc_active(lnk_a.oc_active),
    .tx_dig_rst(lnk_a.tx_dig_rst), .rx_dig_rst(lnk_a.rx_dig_rst),
    .rx_ana_rst(lnk_a.rx_ana_rst), .powerdown(lnk_a.powerdown),
    .freq_locked(lnk_a.freq_locked));
  // Transceiver stand-in: logs each operation, answers after 1 to 4 cycles unless stall is set.
  initial forever begin
    @(negedge core_clk);
    if (st_a === 1'b1) begin
      mlog[nops & 7] = md_a;
      clog[nops & 7] = ch_a;
      nops = nops + 1;
      if (!stall) begin
        repeat (1 + ($unsigned($random(seed)) % 4)) @(posedge core_clk);
        ack_a <= 1'b1;
        @(posedge core_clk);
        ack_a <= 1'b0;
      end
    end
  end
  always @(posedge core_clk) ack_b <= ack_en_b & (st_b === 1'b1);
  always @(posedge core_clk) ack_c <= ack_en_b & (st_c === 1'b1);
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task rw(input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rr(input logic [3:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    v = reg_rdata;
  endtask
  function automatic logic cond(input int s);
    case (s)
      0: cond = irq === 1'b1;
      1: cond = lnk_a.tx_dig_rst === 1'b0;
      2: cond = lnk_a.rx_dig_rst === 1'b0;
      default: cond = lnk_b.busy === 1'b0;
    endcase
  endfunction
  task wait_for(input int s, input int lim, output int k);
    k = 0;
    while (!cond(s)) begin
      if (k == lim) begin
        bad_count++;
        report_and_stop;
      end
      @(negedge core_clk);
      k++;
    end
  endtask
  // One request on the second and third controllers at once; counts the
  // error and busy cycles of the third when c is set, else the second.
  task req_b(input logic [4:0] t, input bit maxv, input bit c,
    input int exp_err, output int kb);
    int ne, nboth;
    logic [31:0] r;
    logic e, bz;
    ne = 0;
    nboth = 0;
    kb = 0;
    r = $random(seed);
    @(posedge core_clk);
    {lnk_b.mode_sel, lnk_b.rd_req, lnk_b.wr_all_req} <= t;
    lnk_b.chan_sel <= r[15:14];
    lnk_b.wdata <= maxv ? 14'h3FFF : r[13:0];
    @(posedge core_clk);
    lnk_b.rd_req <= 1'b0;
    lnk_b.wr_all_req <= 1'b0;
    repeat (40) begin
      @(negedge core_clk);
      e = c ? lnk_c.error : lnk_b.error;
      bz = c ? lnk_c.busy : lnk_b.busy;
      ne += (e === 1'b1);
      kb += (bz === 1'b1);
      nboth += (e === 1'b1 && bz !== 1'b0);
    end
    chk(ne, exp_err);
    chk(nboth, 0);
  endtask
  initial begin
    {lnk_b.mode_sel, lnk_b.rd_req, lnk_b.wr_all_req} = 5'h00;
    lnk_b.wdata = 14'h0000;
    lnk_b.chan_sel = 2'h0;
    lnk_a.freq_locked = 1'b0;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    fork
      rw(`TRC_REG_CTRL, 32'h2);
    join_none
    wait_for(3, 100, n);
    // The loop also counts the first cycle that shows busy low.
    chk(n, `TRC_OC_SIM_CYC + 1);
    // Powerdown is registered after cancellation ends, one cycle later.
    @(negedge core_clk);
    chk(lnk_a.powerdown, 1'b1);
    rw(`TRC_REG_CTRL, 32'h0);
    rr(4'h1, d);
    chk(d, 32'h0);
    rr(`TRC_REG_MASK, d);
    chk(d, `TRC_MASK_RST);
    rw(`TRC_REG_MASK, 32'h2);
    $display("test reset and registers done");
    stall = 1'b1;
    rw(`TRC_REG_CTRL, 32'h1);
    wait_for(0, 200, n);
    stall = 1'b0;
    rr(`TRC_REG_EVT, d);
    chk(d, 32'h2);
    rr(`TRC_REG_STAT, d);
    chk(d[9:7], 3'h7);
    rw(`TRC_REG_EVT, 32'h2);
    @(negedge core_clk);
    chk(irq, 1'b0);
    $display("test pll timeout done");
    nops = 0;
    rw(`TRC_REG_CTRL, 32'h1);
    wait_for(1, 500, n);
    chk(nops, 5);
    chk(mlog[0], `TRC_MODE_PLL);
    for (int i = 1; i < 5; i++) begin
      chk({mlog[i], clog[i]}, {`TRC_MODE_CHAN, 2'(i - 1)});
    end
    chk({lnk_a.rx_ana_rst, lnk_a.rx_dig_rst}, 2'h1);
    @(posedge core_clk);
    lnk_a.freq_locked <= 1'b1;
    repeat (40) @(posedge core_clk);
    lnk_a.freq_locked <= 1'b0;
    @(posedge core_clk);
    lnk_a.freq_locked <= 1'b1;
    repeat (75) @(posedge core_clk);
    @(negedge core_clk);
    chk(lnk_a.rx_dig_rst, 1'b1);
    wait_for(2, 20, n);
    chk(75 + n >= 80 && 75 + n <= 82, 1'b1);
    rr(`TRC_REG_EVT, d);
    chk(d, 32'h1);
    chk(irq, 1'b0);
    rw(`TRC_REG_MASK, 32'h3);
    @(negedge core_clk);
    chk(irq, 1'b1);
    rw(`TRC_REG_EVT, 32'h3);
    @(negedge core_clk);
    chk(irq, 1'b0);
    $display("test reset sequence done");
    for (int i = 0; i < 3; i++) begin
      req_b(tbl[i], 1'b0, 1'b0, `TRC_ERR_CYC, nb);
      chk(nb, 0);
    end
    for (int i = 0; i < 3; i++) begin
      req_b(5'b00001, i == 0, 1'b1, 0, nb);
      chk(nb > 0, 1'b1);
      chk(pma_c, lnk_b.wdata);
    end
    ack_en_b = 1'b0;
    req_b(5'b01001, 1'b0, 1'b0, `TRC_ERR_CYC, nb);
    chk(nb >= TO && nb <= TO + 1, 1'b1);
    $display("test illegal and timeout done");
    report_and_stop;
  end
  initial begin
    #5000000;
    bad_count++;
    report_and_stop;
  end
endmodule

// ---- rtl/trc_ctrl.sv ----
/*
  Reconfiguration controller end: offset cancellation after reset,
  operation dispatch to the transceiver, illegal operation checking,
  timeout recovery and the error pulse.
  Assumes one clock, the link on trc_if.ctrl and a transceiver that
  answers each started operation with a one-cycle xcvr_op_ack.
*/
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`include "trc_defines.svh"
module trc_ctrl #(
  parameter int CH_W = 2,
  parameter bit CHK_ILLEGAL = 1'b1,
  parameter bit SELF_RECOVER = 1'b1,
  parameter bit HAS_PMA_RD = 1'b1,
  parameter bit HAS_PMA_WR = 1'b1,
  parameter bit SIM_MODEL = 1'b1,
  parameter int OC_HW_CYCLES = `TRC_OC_HW_CYC,
  parameter int OP_TIMEOUT = `TRC_OP_TIMEOUT_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  trc_if.ctrl lnk,
  output logic xcvr_op_start,
  output logic xcvr_op_write,
  output logic [2:0] xcvr_mode,
  output logic [CH_W-1:0] xcvr_chan,
  output trc_pkg::trc_pma_t xcvr_pma,
  input wire logic xcvr_op_ack
);

  localparam int OC_CYC = SIM_MODEL ? `TRC_OC_SIM_CYC : OC_HW_CYCLES;
  localparam logic [`TRC_CNT_W-1:0] OC_LAST = `TRC_CNT_W'(OC_CYC - 1);
  localparam logic [`TRC_CNT_W-1:0] TO_LAST = `TRC_CNT_W'(OP_TIMEOUT - 1);
  localparam logic [`TRC_CNT_W-1:0] ERR_LAST =
    `TRC_CNT_W'(`TRC_ERR_CYC - 1);
  localparam bit ERR_EN = CHK_ILLEGAL | SELF_RECOVER;

  trc_pkg::trc_dev_st_t state_reg;
  trc_pkg::trc_dev_st_t state_next;
  logic [`TRC_CNT_W-1:0] cnt_reg;
  logic [`TRC_CNT_W-1:0] cnt_next;
  logic busy_reg;
  logic busy_next;
  logic error_reg;
  logic error_next;
  logic start_reg;
  logic start_next;
  logic write_reg;
  logic write_next;
  logic pma_rd_reg;
  logic pma_rd_next;
  logic [2:0] mode_reg;
  logic [2:0] mode_next;
  logic [CH_W-1:0] chan_reg;
  logic [CH_W-1:0] chan_next;
  trc_pkg::trc_pma_t pma_reg;
  trc_pkg::trc_pma_t pma_next;
  trc_pkg::trc_pma_t rdata_reg;
  trc_pkg::trc_pma_t rdata_next;
  logic oc_reg;
  logic oc_next;
  logic req;
  logic illegal;

  // Decides whether a request may not be carried out by this instance.
  function automatic logic is_illegal(input logic rd, input logic wr,
                                      input logic [2:0] mode);
    logic bad;
    bad = 1'b0;
    if (rd && mode == `TRC_MODE_PMA && !HAS_PMA_RD) begin
      bad = 1'b1;
    end
    if (wr && mode == `TRC_MODE_PMA && !HAS_PMA_WR) begin
      bad = 1'b1;
    end
    if (rd && mode == `TRC_MODE_CHAN) begin
      bad = 1'b1;
    end
    return bad;
  endfunction

  assign req = lnk.rd_req | lnk.wr_all_req;
  assign illegal = CHK_ILLEGAL &&
                   is_illegal(lnk.rd_req, lnk.wr_all_req, lnk.mode_sel);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    error_next = 1'b0;
    start_next = 1'b0;
    write_next = write_reg;
    pma_rd_next = pma_rd_reg;
    mode_next = mode_reg;
    chan_next = chan_reg;
    pma_next = pma_reg;
    rdata_next = rdata_reg;
    oc_next = 1'b0;
    unique case (state_reg)
      trc_pkg::TRC_ST_OFFCAN: begin
        if (cnt_reg == OC_LAST) begin
          state_next = trc_pkg::TRC_ST_IDLE;
          busy_next = 1'b0;
          cnt_next = '0;
        end else begin
          oc_next = 1'b1;
          cnt_next = cnt_reg + `TRC_CNT_W'(1);
        end
      end
      trc_pkg::TRC_ST_IDLE: begin
        if (req && illegal) begin
          state_next = trc_pkg::TRC_ST_ERR;
          busy_next = 1'b0;
          error_next = ERR_EN;
          cnt_next = '0;
        end else if (req) begin
          state_next = trc_pkg::TRC_ST_RUN;
          busy_next = 1'b1;
          start_next = 1'b1;
          cnt_next = '0;
          write_next = lnk.wr_all_req;
          pma_rd_next = lnk.rd_req && lnk.mode_sel == `TRC_MODE_PMA;
          mode_next = lnk.mode_sel;
          chan_next = lnk.chan_sel;
          if (lnk.wr_all_req && lnk.mode_sel == `TRC_MODE_PMA) begin
            pma_next = lnk.wdata;
          end
        end
      end
      trc_pkg::TRC_ST_RUN: begin
        if (xcvr_op_ack) begin
          state_next = trc_pkg::TRC_ST_IDLE;
          busy_next = 1'b0;
          if (pma_rd_reg) begin
            rdata_next = pma_reg;
          end
        end else if (SELF_RECOVER && cnt_reg == TO_LAST) begin
          state_next = trc_pkg::TRC_ST_ERR;
          busy_next = 1'b0;
          error_next = ERR_EN;
          cnt_next = '0;
        end else begin
          cnt_next = cnt_reg + `TRC_CNT_W'(1);
        end
      end
      trc_pkg::TRC_ST_ERR: begin
        busy_next = 1'b0;
        if (cnt_reg == ERR_LAST) begin
          state_next = trc_pkg::TRC_ST_IDLE;
          cnt_next = '0;
        end else begin
          error_next = ERR_EN;
          cnt_next = cnt_reg + `TRC_CNT_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= trc_pkg::TRC_ST_OFFCAN;
      cnt_reg <= '0;
      busy_reg <= 1'b1;
      error_reg <= 1'b0;
      start_reg <= 1'b0;
      write_reg <= 1'b0;
      pma_rd_reg <= 1'b0;
      mode_reg <= `TRC_MODE_PMA;
      chan_reg <= '0;
      pma_reg <= '0;
      rdata_reg <= '0;
      oc_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      error_reg <= error_next;
      start_reg <= start_next;
      write_reg <= write_next;
      pma_rd_reg <= pma_rd_next;
      mode_reg <= mode_next;
      chan_reg <= chan_next;
      pma_reg <= pma_next;
      rdata_reg <= rdata_next;
      oc_reg <= oc_next;
    end
  end

  // Busy and error come straight from flip-flops, so the user side sees
  // them change only after a clock edge and never glitch together.
  assign lnk.busy = busy_reg;
  assign lnk.error = error_reg;
  assign lnk.rdata = rdata_reg;
  assign lnk.oc_active = oc_reg;
  assign xcvr_op_start = start_reg;
  assign xcvr_op_write = write_reg;
  assign xcvr_mode = mode_reg;
  assign xcvr_chan = chan_reg;
  assign xcvr_pma = pma_reg;

endmodule

// ---- rtl/trc_defines.svh ----
/*
  Constants shared by both ends of the reconfiguration error and reset
  sequencing link: operation codes, timing figures and register map.
  Assumes it is included by its bare name from files under rtl/.
*/
`ifndef TRC_DEFINES_SVH
`define TRC_DEFINES_SVH

// Operation selector codes.
`define TRC_MODE_PMA 3'h0
`define TRC_MODE_CHAN 3'h1
`define TRC_MODE_PLL 3'h2

// Clock and timing figures.
`define TRC_CLK_MHZ 20
`define TRC_CNT_W 16
`define TRC_OC_SIM_CYC 16
`define TRC_OC_HW_CYC 4000
`define TRC_ERR_CYC 2
`define TRC_OP_TIMEOUT_CYC 1024
`define TRC_LOCK_WAIT_NS 4000
`define TRC_LOCK_WAIT_CYC ((`TRC_LOCK_WAIT_NS * `TRC_CLK_MHZ + 999) / 1000)

// Sequencer register map, byte offsets.
`define TRC_REG_CTRL 4'h0
`define TRC_REG_STAT 4'h4
`define TRC_REG_EVT 4'h8
`define TRC_REG_MASK 4'hC

// Field positions.
`define TRC_CTRL_START 0
`define TRC_CTRL_PDOWN 1
`define TRC_EVT_DONE 0
`define TRC_EVT_ERR 1
`define TRC_EVT_W 2

// Reset values.
`define TRC_MASK_RST 2'h0
`define TRC_RSTS_RST 1'h1

`endif

// ---- rtl/trc_if.sv ----
/*
  Link between the reconfiguration controller and the user reset
  sequencer. freq_locked comes from the transceiver and is driven by
  the surroundings; both ends only read it.
*/
`timescale 1ns/10ps
interface trc_if #(
  parameter int CH_W = 2
);
  logic [2:0] mode_sel;
  logic [CH_W-1:0] chan_sel;
  logic rd_req;
  logic wr_all_req;
  trc_pkg::trc_pma_t wdata;
  trc_pkg::trc_pma_t rdata;
  logic busy;
  logic error;
  logic oc_active;
  logic tx_dig_rst;
  logic rx_dig_rst;
  logic rx_ana_rst;
  logic powerdown;
  logic freq_locked;

  modport ctrl (
    input mode_sel, chan_sel, rd_req, wr_all_req, wdata, freq_locked,
    output rdata, busy, error, oc_active
  );

  modport user (
    output mode_sel, chan_sel, rd_req, wr_all_req, wdata,
    output tx_dig_rst, rx_dig_rst, rx_ana_rst, powerdown,
    input rdata, busy, error, oc_active, freq_locked
  );
endinterface

// ---- rtl/trc_pkg.sv ----
/*
  Types for the reconfiguration error and reset sequencing link.
  Assumes trc_defines.svh is available for the numeric constants.
*/
package trc_pkg;

  // Analog control settings carried as one word.
  typedef struct packed {
    logic [3:0] eq;
    logic [1:0] dcgain;
    logic [2:0] swing;
    logic [4:0] preemp;
  } trc_pma_t;

  typedef enum logic [3:0] {
    TRC_ST_OFFCAN = 4'b0001,
    TRC_ST_IDLE = 4'b0010,
    TRC_ST_RUN = 4'b0100,
    TRC_ST_ERR = 4'b1000
  } trc_dev_st_t;

  typedef enum logic [6:0] {
    TRC_SQ_IDLE = 7'b0000001,
    TRC_SQ_PLL = 7'b0000010,
    TRC_SQ_CHAN = 7'b0000100,
    TRC_SQ_GAP = 7'b0001000,
    TRC_SQ_WAIT = 7'b0010000,
    TRC_SQ_LOCK = 7'b0100000,
    TRC_SQ_HOLD = 7'b1000000
  } trc_seq_st_t;

endpackage

// ---- rtl/trc_user.sv ----
/*
  User-side reset sequencer for a PLL update with a new feedback
  value, with a small register port, sticky events and an interrupt.
  Assumes one clock and the controller on trc_if.user.
*/
`timescale 1ns/10ps
`include "trc_defines.svh"
module trc_user #(
  parameter int CH_W = 2,
  parameter int NUM_CH = 4
) (
  input wire logic core_clk,
  input wire logic resetn,
  trc_if.user lnk,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);

  localparam logic [7:0] LOCK_LAST = 8'(`TRC_LOCK_WAIT_CYC - 1);
  localparam logic [CH_W-1:0] CH_LAST = CH_W'(NUM_CH - 1);

  trc_pkg::trc_seq_st_t st_reg;
  trc_pkg::trc_seq_st_t st_next;
  logic pll_ph_reg;
  logic pll_ph_next;
  logic [CH_W-1:0] ch_reg;
  logic [CH_W-1:0] ch_next;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic req_reg;
  logic req_next;
  logic [2:0] mode_reg;
  logic [2:0] mode_next;
  logic [2:0] rst_reg;
  logic [2:0] rst_next;
  logic pd_reg;
  logic pd_next;
  logic pd_out_reg;
  logic pd_out_next;
  logic [`TRC_EVT_W-1:0] evt_reg;
  logic [`TRC_EVT_W-1:0] evt_next;
  logic [`TRC_EVT_W-1:0] mask_reg;
  logic [`TRC_EVT_W-1:0] mask_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [`TRC_EVT_W-1:0] ev_set;
  logic start;

  assign start = reg_wr && reg_addr == `TRC_REG_CTRL &&
                 reg_wdata[`TRC_CTRL_START];

  always_comb begin
    st_next = st_reg;
    pll_ph_next = pll_ph_reg;
    ch_next = ch_reg;
    cnt_next = cnt_reg;
    req_next = 1'b0;
    mode_next = mode_reg;
    rst_next = rst_reg;
    ev_set = '0;
    unique case (st_reg)
      trc_pkg::TRC_SQ_IDLE: begin
        // A start while the controller is busy is dropped.
        if (start && !lnk.busy) begin
          rst_next = 3'h7;
          pll_ph_next = 1'b1;
          st_next = trc_pkg::TRC_SQ_PLL;
        end
      end
      trc_pkg::TRC_SQ_PLL: begin
        mode_next = `TRC_MODE_PLL;
        req_next = 1'b1;
        st_next = trc_pkg::TRC_SQ_GAP;
      end
      trc_pkg::TRC_SQ_CHAN: begin
        mode_next = `TRC_MODE_CHAN;
        req_next = 1'b1;
        st_next = trc_pkg::TRC_SQ_GAP;
      end
      trc_pkg::TRC_SQ_GAP: begin
        // Gives the controller time to raise busy or flag an error.
        st_next = trc_pkg::TRC_SQ_WAIT;
      end
      trc_pkg::TRC_SQ_WAIT: begin
        if (lnk.error) begin
          ev_set[`TRC_EVT_ERR] = 1'b1;
          st_next = trc_pkg::TRC_SQ_IDLE;
        end else if (!lnk.busy) begin
          if (pll_ph_reg) begin
            pll_ph_next = 1'b0;
            ch_next = '0;
            st_next = trc_pkg::TRC_SQ_CHAN;
          end else if (ch_reg != CH_LAST) begin
            ch_next = ch_reg + CH_W'(1);
            st_next = trc_pkg::TRC_SQ_CHAN;
          end else begin
            rst_next = 3'h1;
            st_next = trc_pkg::TRC_SQ_LOCK;
          end
        end
      end
      trc_pkg::TRC_SQ_LOCK: begin
        cnt_next = '0;
        if (lnk.freq_locked) begin
          st_next = trc_pkg::TRC_SQ_HOLD;
        end
      end
      trc_pkg::TRC_SQ_HOLD: begin
        if (!lnk.freq_locked) begin
          st_next = trc_pkg::TRC_SQ_LOCK;
        end else if (cnt_reg == LOCK_LAST) begin
          rst_next = 3'h0;
          ev_set[`TRC_EVT_DONE] = 1'b1;
          st_next = trc_pkg::TRC_SQ_IDLE;
        end else begin
          cnt_next = cnt_reg + 8'h01;
        end
      end
    endcase
  end

  always_comb begin
    pd_next = pd_reg;
    mask_next = mask_reg;
    // Set wins over a write-one clear in the same cycle.
    evt_next = evt_reg | ev_set;
    rdata_next = '0;
    if (reg_wr) begin
      unique case (reg_addr)
        `TRC_REG_CTRL: pd_next = reg_wdata[`TRC_CTRL_PDOWN];
        `TRC_REG_EVT: evt_next = (evt_reg & ~reg_wdata[`TRC_EVT_W-1:0]) |
                                 ev_set;
        `TRC_REG_MASK: mask_next = reg_wdata[`TRC_EVT_W-1:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `TRC_REG_CTRL: rdata_next[`TRC_CTRL_PDOWN] = pd_reg;
        `TRC_REG_STAT: rdata_next = {20'h0, lnk.oc_active, lnk.busy,
                                     rst_reg, st_reg};
        `TRC_REG_EVT: rdata_next[`TRC_EVT_W-1:0] = evt_reg;
        `TRC_REG_MASK: rdata_next[`TRC_EVT_W-1:0] = mask_reg;
        default: rdata_next = '0;
      endcase
    end
    pd_out_next = pd_next && !lnk.oc_active;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= trc_pkg::TRC_SQ_IDLE;
      pll_ph_reg <= 1'b0;
      ch_reg <= '0;
      cnt_reg <= '0;
      req_reg <= 1'b0;
      mode_reg <= `TRC_MODE_PMA;
      rst_reg <= {3{`TRC_RSTS_RST}};
      pd_reg <= 1'b0;
      pd_out_reg <= 1'b0;
      evt_reg <= '0;
      mask_reg <= `TRC_MASK_RST;
      rdata_reg <= '0;
    end else begin
      st_reg <= st_next;
      pll_ph_reg <= pll_ph_next;
      ch_reg <= ch_next;
      cnt_reg <= cnt_next;
      req_reg <= req_next;
      mode_reg <= mode_next;
      rst_reg <= rst_next;
      pd_reg <= pd_next;
      pd_out_reg <= pd_out_next;
      evt_reg <= evt_next;
      mask_reg <= mask_next;
      rdata_reg <= rdata_next;
    end
  end

  assign lnk.mode_sel = mode_reg;
  assign lnk.chan_sel = ch_reg;
  assign lnk.rd_req = 1'b0;
  assign lnk.wr_all_req = req_reg;
  assign lnk.wdata = '0;
  assign lnk.tx_dig_rst = rst_reg[2];
  assign lnk.rx_ana_rst = rst_reg[1];
  assign lnk.rx_dig_rst = rst_reg[0];
  assign lnk.powerdown = pd_out_reg;
  assign reg_rdata = rdata_reg;
  assign irq = |(evt_reg & mask_reg);

endmodule
